/* logic/csd_clock_select.sv */
// clock source selection and division: registers, lock, per-consumer clock enables
// assumes: one 40 MHz clk; every source clock arrives as a one-cycle enable pulse on clk,
// produced by logic on the same clock, so no synchroniser is needed on them
`include "csd_cfg.svh"

//Function
//- tick clock chosen by tick source field, or core clock while tick_clock_is_core is set
//- protected fields written only while unlocked
//- core clock source from core select field
//- pwm pairs 0 and 1 use core clock
//- pwm pair 2 uses core clock
//- serial clock crystal or fast oscillator
//- timers choose among five sources
//- converter clock source from two-bit field
//- watchdog clock protected, core/2048 option
//- divider input chosen by two-bit field
//- crystal code routes enabled crystal
//- converter clock divided by count plus one
//- serial clock divided by count plus one
//- core clock divided by count plus one
//- divider output runs only when enabled
//- divider output is input over 2^(n+1)
//- select registers reset to documented defaults
//- crystal enable field encodes four modes; here 01 and 11 both route the fast crystal
//- unstable switch target sets sticky fail flag
module csd_clock_select (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic      [31:0]             reg_rdata,
  // source pulses and status
  input  wire csd_pkg::csd_src_type    src_tick,
  input  wire csd_pkg::csd_stable_type src_stable,
  input  wire logic                    tick_clock_is_core,
  // derived clock enables, divider output and crystal enable field
  output logic                         core_clk_en,
  output logic                         tick_clk_en,
  output logic                         pwm_pair0_clk_en,
  output logic                         pwm_pair1_clk_en,
  output logic                         pwm_pair2_clk_en,
  output logic                         serial_clk_en,
  output logic                         timer_a_clk_en,
  output logic                         timer_b_clk_en,
  output logic                         converter_clk_en,
  output logic                         watchdog_clk_en,
  output logic                         divider_out_reg,
  output logic [1:0]                   crystal_enable_field
);

  logic [31:0]           sel0_reg;
  logic [31:0]           sel1_reg;
  logic [31:0]           sel2_reg;
  logic [31:0]           div_reg;
  logic [31:0]           fdiv_reg;
  logic [1:0]            xtal_reg;
  logic                  fail_reg;
  csd_pkg::csd_lock_type lock_reg;
  logic                  wr_unlock;
  logic                  xtal_tick;
  logic                  xtal_stable;
  logic [31:0]           sel0_next;
  logic [31:0]           sel1_next;
  logic                  prot_write;
  logic                  bad_switch;

  assign wr_unlock  = reg_write && reg_addr == `CSD_OFS_UNLOCK;
  assign prot_write = reg_write && lock_reg == csd_pkg::CSD_OPEN;

  // unlock key sequence; any wrong byte relocks, a right sequence stays open until
  // the next write of any value, even a key byte, to the unlock address
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_reg <= csd_pkg::CSD_LOCKED;
    end else if (wr_unlock) begin
      unique case (lock_reg)
        csd_pkg::CSD_LOCKED: lock_reg <= (reg_wdata[7:0] == `CSD_KEY0) ? csd_pkg::CSD_KEY1 : csd_pkg::CSD_LOCKED;
        csd_pkg::CSD_KEY1:   lock_reg <= (reg_wdata[7:0] == `CSD_KEY1) ? csd_pkg::CSD_KEY2 : csd_pkg::CSD_LOCKED;
        csd_pkg::CSD_KEY2:   lock_reg <= (reg_wdata[7:0] == `CSD_KEY2) ? csd_pkg::CSD_OPEN : csd_pkg::CSD_LOCKED;
        csd_pkg::CSD_OPEN:   lock_reg <= csd_pkg::CSD_LOCKED;
      endcase
    end
  end

  // protected fields keep their value unless the lock is open
  always_comb begin
    sel0_next = sel0_reg;
    sel1_next = sel1_reg;
    if (reg_write && reg_addr == `CSD_OFS_SEL0 && prot_write) begin
      sel0_next = reg_wdata & `CSD_SEL0_MASK;
    end
    if (reg_write && reg_addr == `CSD_OFS_SEL1) begin
      sel1_next = reg_wdata & `CSD_SEL1_MASK;
      if (!prot_write) begin
        sel1_next[1:0] = sel1_reg[1:0];
      end
    end
  end

  // switching to a source that is not stable is flagged
  always_comb begin
    bad_switch = 1'b0;
    if (sel0_next[2:0] != sel0_reg[2:0]) begin
      unique case (sel0_next[2:0])
        3'h0: bad_switch = !xtal_stable;
        3'h3: bad_switch = !src_stable.slow_irc_stable;
        3'h7: bad_switch = !src_stable.fast_irc_stable;
        default: bad_switch = 1'b0;
      endcase
    end
  end

  // register file writes; reset restores the default selections
  always_ff @(posedge clk) begin
    if (reset) begin
      sel0_reg <= `CSD_RST_SEL0;
      sel1_reg <= `CSD_RST_SEL1;
      sel2_reg <= `CSD_RST_SEL2;
      div_reg  <= `CSD_RST_ZERO;
      fdiv_reg <= `CSD_RST_ZERO;
      xtal_reg <= 2'h0;
    end else begin
      sel0_reg <= sel0_next;
      sel1_reg <= sel1_next;
      if (reg_write && reg_addr == `CSD_OFS_SEL2) sel2_reg <= reg_wdata & `CSD_SEL2_MASK;
      if (reg_write && reg_addr == `CSD_OFS_DIV) div_reg <= reg_wdata & `CSD_DIV_MASK;
      if (reg_write && reg_addr == `CSD_OFS_FDIV) fdiv_reg <= reg_wdata & `CSD_FDIV_MASK;
      if (reg_write && reg_addr == `CSD_OFS_PWR) xtal_reg <= reg_wdata[1:0];
    end
  end

  // sticky fail flag; a new failure wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_reg <= 1'b0;
    end else if (bad_switch) begin
      fail_reg <= 1'b1;
    end else if (reg_write && reg_addr == `CSD_OFS_STAT && reg_wdata[`CSD_SW_FAIL_BIT]) begin
      fail_reg <= 1'b0;
    end
  end

  // crystal route: 01 and 11 use the fast pin, 10 the slow crystal, 00 nothing
  always_comb begin
    unique case (xtal_reg)
      2'h0: xtal_tick = 1'b0;
      2'h2: xtal_tick = src_tick.slow_crystal;
      default: xtal_tick = src_tick.fast_crystal;
    endcase
    xtal_stable = src_stable.crystal_stable && xtal_reg != 2'h0;
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `CSD_RST_ZERO;
    end else if (reg_read) begin
      unique case (reg_addr)
        `CSD_OFS_SEL0: reg_rdata <= sel0_reg;
        `CSD_OFS_SEL1: reg_rdata <= sel1_reg;
        `CSD_OFS_SEL2: reg_rdata <= sel2_reg;
        `CSD_OFS_DIV:  reg_rdata <= div_reg;
        `CSD_OFS_FDIV: reg_rdata <= fdiv_reg;
        `CSD_OFS_PWR:  reg_rdata <= {30'h0, xtal_reg};
        `CSD_OFS_STAT: reg_rdata <= {24'h0, fail_reg, 2'h0, src_stable.fast_irc_stable,
                                     src_stable.slow_irc_stable, 2'h0, xtal_stable};
        `CSD_OFS_UNLOCK: reg_rdata <= {31'h0, lock_reg == csd_pkg::CSD_OPEN};
        default:       reg_rdata <= `CSD_RST_ZERO;
      endcase
    end
  end

  // core source mux; reserved codes hold the last valid choice
  logic [1:0] core_src_reg;
  logic       core_src_tick;
  logic       core_raw;
  always_ff @(posedge clk) begin
    if (reset) begin
      core_src_reg <= 2'h2;
    end else begin
      unique case (sel0_reg[2:0])
        3'h0: core_src_reg <= 2'h0;
        3'h3: core_src_reg <= 2'h1;
        3'h7: core_src_reg <= 2'h2;
        default: core_src_reg <= core_src_reg;
      endcase
    end
  end
  always_comb begin
    unique case (core_src_reg)
      2'h0: core_src_tick = xtal_tick;
      2'h1: core_src_tick = src_tick.slow_internal_oscillator;
      default: core_src_tick = src_tick.fast_internal_oscillator;
    endcase
  end

  // counters share one form: count source pulses, reload the new count only on wrap
  localparam int NDIV = 3;
  logic [7:0] div_cnt_reg [NDIV];
  logic [7:0] div_lim_reg [NDIV];
  logic       div_in      [NDIV];
  logic [7:0] div_new     [NDIV];
  logic       div_hit     [NDIV];
  assign div_new[0] = {4'h0, div_reg[3:0]};
  assign div_new[1] = {4'h0, div_reg[11:8]};
  assign div_new[2] = div_reg[23:16];
  genvar gi;
  generate
    for (gi = 0; gi < NDIV; gi++) begin : g_div
      assign div_hit[gi] = div_in[gi] && div_cnt_reg[gi] == div_lim_reg[gi];
      always_ff @(posedge clk) begin
        if (reset) begin
          div_cnt_reg[gi] <= 8'h00;
          div_lim_reg[gi] <= 8'h00;
        end else if (div_hit[gi]) begin
          div_cnt_reg[gi] <= 8'h00;
          div_lim_reg[gi] <= div_new[gi];
        end else if (div_in[gi]) begin
          div_cnt_reg[gi] <= div_cnt_reg[gi] + 8'h01;
        end
      end
    end
  endgenerate
  assign div_in[0] = core_src_tick;
  assign core_raw  = div_hit[0];

  // serial, converter, watchdog, divider, tick and timer sources; reserved codes fall back to held choice
  logic [1:0] ser_src_reg;
  logic [1:0] adc_src_reg;
  logic [1:0] wdt_src_reg;
  logic [1:0] frq_src_reg;
  logic [1:0] tick_src_reg;
  logic [2:0] tma_src_reg;
  logic [2:0] tmb_src_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      ser_src_reg  <= 2'h2;
      adc_src_reg  <= 2'h3;
      wdt_src_reg  <= 2'h3;
      frq_src_reg  <= 2'h3;
      tick_src_reg <= 2'h3;
      tma_src_reg  <= 3'h7;
      tmb_src_reg  <= 3'h7;
    end else begin
      if (sel1_reg[25:24] != 2'h1 && sel1_reg[25:24] != 2'h3) ser_src_reg <= sel1_reg[25:24];
      if (sel1_reg[3:2] != 2'h1) adc_src_reg <= sel1_reg[3:2];
      if (sel1_reg[1:0] != 2'h1) wdt_src_reg <= sel1_reg[1:0];
      if (sel2_reg[3:2] != 2'h1) frq_src_reg <= sel2_reg[3:2];
      // tick codes 000,010,011,111 map to held choices 0,2,1,3; 1 is core/2, which
      // the top two code bits alone cannot tell apart from crystal/2 (code 010)
      if (sel0_reg[5:3] == 3'h0 || sel0_reg[5:3] == 3'h2 || sel0_reg[5:3] == 3'h3 ||
          sel0_reg[5:3] == 3'h7) begin
        tick_src_reg <= {sel0_reg[5] | (sel0_reg[4] & ~sel0_reg[3]), sel0_reg[3]};
      end
      if (sel1_reg[10:8] < 3'h4 || sel1_reg[10:8] == 3'h7) tma_src_reg <= sel1_reg[10:8];
      if (sel1_reg[14:12] < 3'h4 || sel1_reg[14:12] == 3'h7) tmb_src_reg <= sel1_reg[14:12];
    end
  end

  // shared five-way source pick: crystal, slow osc, core, trigger, fast osc
  function automatic logic pick(input logic [2:0] code, input logic xt, input logic core,
                                input csd_pkg::csd_src_type s);
    unique case (code)
      3'h0: pick = xt;
      3'h1: pick = s.slow_internal_oscillator;
      3'h2: pick = core;
      3'h3: pick = s.ext_trigger;
      default: pick = s.fast_internal_oscillator;
    endcase
  endfunction : pick

  assign div_in[1] = (ser_src_reg == 2'h0) ? xtal_tick : src_tick.fast_internal_oscillator;
  assign div_in[2] = pick({adc_src_reg == 2'h3, adc_src_reg[1] & ~adc_src_reg[0], 1'b0},
                          xtal_tick, core_raw, src_tick);

  // one halving stage for the tick source and core/2048 for the watchdog
  logic        half_in;
  logic        half_reg;
  logic [10:0] wdt_cnt_reg;
  always_comb begin
    unique case (tick_src_reg)
      2'h0, 2'h2: half_in = xtal_tick;
      2'h3: half_in = src_tick.fast_internal_oscillator;
      default: half_in = core_raw;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      half_reg    <= 1'b0;
      wdt_cnt_reg <= 11'h000;
    end else begin
      if (half_in) half_reg <= ~half_reg;
      if (core_raw) wdt_cnt_reg <= wdt_cnt_reg + 11'h001;
    end
  end

  // frequency divider output: toggle at bit divider_output_select of a pulse counter, so the period is
  // 2^(divider_output_select+1) input pulses; counter and output cleared while disabled
  logic        frq_in;
  logic [15:0] frq_cnt_reg;
  logic        frq_hit;
  assign frq_in  = pick({frq_src_reg == 2'h3, frq_src_reg[1] & ~frq_src_reg[0], 1'b0},
                        xtal_tick, core_raw, src_tick);
  assign frq_hit = frq_in && ((frq_cnt_reg & ((16'h0001 << fdiv_reg[3:0]) - 16'h0001)) ==
                              ((16'h0001 << fdiv_reg[3:0]) - 16'h0001));
  always_ff @(posedge clk) begin
    if (reset || !fdiv_reg[4]) begin
      frq_cnt_reg     <= 16'h0000;
      divider_out_reg <= 1'b0;
    end else if (frq_in) begin
      frq_cnt_reg <= frq_cnt_reg + 16'h0001;
      if (frq_hit) divider_out_reg <= ~divider_out_reg;
    end
  end

  // all enables registered; pulse style keeps every edge whole through a switch
  always_ff @(posedge clk) begin
    if (reset) begin
      core_clk_en      <= 1'b0;
      tick_clk_en      <= 1'b0;
      pwm_pair0_clk_en <= 1'b0;
      pwm_pair1_clk_en <= 1'b0;
      pwm_pair2_clk_en <= 1'b0;
      serial_clk_en    <= 1'b0;
      timer_a_clk_en   <= 1'b0;
      timer_b_clk_en   <= 1'b0;
      converter_clk_en <= 1'b0;
      watchdog_clk_en  <= 1'b0;
    end else begin
      core_clk_en      <= core_raw;
      tick_clk_en      <= tick_clock_is_core ? core_raw :
                          ((tick_src_reg == 2'h0) ? xtal_tick : half_in && half_reg);
      pwm_pair0_clk_en <= core_raw;
      pwm_pair1_clk_en <= core_raw;
      pwm_pair2_clk_en <= core_raw;
      serial_clk_en    <= div_hit[1];
      timer_a_clk_en   <= pick(tma_src_reg, xtal_tick, core_raw, src_tick);
      timer_b_clk_en   <= pick(tmb_src_reg, xtal_tick, core_raw, src_tick);
      converter_clk_en <= div_hit[2];
      watchdog_clk_en  <= (wdt_src_reg == 2'h0) ? xtal_tick :
                          (wdt_src_reg == 2'h2) ? core_raw && wdt_cnt_reg == `CSD_WDT_DIV :
                          src_tick.slow_internal_oscillator;
    end
  end

  assign crystal_enable_field = xtal_reg;

  // a locked write must leave the watchdog field alone
  a_wdt_locked_hold: assert property (@(posedge clk) disable iff (reset)
    (reg_write && reg_addr == `CSD_OFS_SEL1 && lock_reg != csd_pkg::CSD_OPEN)
      |=> sel1_reg[1:0] == $past(sel1_reg[1:0]))
    else $error("watchdog field changed while locked");

  a_core_locked_hold: assert property (@(posedge clk) disable iff (reset)
    (reg_write && reg_addr == `CSD_OFS_SEL0 && lock_reg != csd_pkg::CSD_OPEN)
      |=> $stable(sel0_reg))
    else $error("core select changed while locked");

  a_fail_sticky: assert property (@(posedge clk) disable iff (reset)
    bad_switch |=> fail_reg)
    else $error("switch fail flag not set");

  a_divider_off: assert property (@(posedge clk) disable iff (reset)
    !fdiv_reg[4] |=> !divider_out_reg)
    else $error("divider output runs while disabled");

  a_core_period: assert property (@(posedge clk) disable iff (reset)
    core_raw |-> div_lim_reg[0] == $past(div_lim_reg[0]) || $past(div_hit[0]))
    else $error("core count reloaded mid period");

  a_reserved_core: assert property (@(posedge clk) disable iff (reset)
    (sel0_reg[2:0] == 3'h1) |=> $stable(core_src_reg))
    else $error("reserved code moved core source");

  a_pwm_follow: assert property (@(posedge clk) disable iff (reset)
    core_raw |=> pwm_pair0_clk_en && pwm_pair1_clk_en && pwm_pair2_clk_en && core_clk_en)
    else $error("pwm enables do not follow core clock");

  a_reset_sel1: assert property (@(posedge clk)
    reset |=> sel1_reg == `CSD_RST_SEL1 && sel2_reg == `CSD_RST_SEL2)
    else $error("select registers not at reset defaults");

endmodule : csd_clock_select

/* logic/csd_cfg.svh */
// register offsets, field positions, reset values and codes for the clock select/divide block
// assumes: included by the top module by bare name
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH
`define CSD_OFS_SEL0      8'h10
`define CSD_OFS_SEL1      8'h14
`define CSD_OFS_DIV       8'h18
`define CSD_OFS_SEL2      8'h1C
`define CSD_OFS_FDIV      8'h24
`define CSD_OFS_PWR       8'h00
`define CSD_OFS_STAT      8'h0C
`define CSD_OFS_UNLOCK    8'h30
`define CSD_RST_SEL0      32'h0000003F
`define CSD_RST_SEL1      32'hAFFFFFFF
`define CSD_RST_SEL2      32'h000000EF
`define CSD_RST_ZERO      32'h00000000
`define CSD_KEY0          8'h59
`define CSD_KEY1          8'h16
`define CSD_KEY2          8'h88
`define CSD_SEL0_MASK     32'h0000003F
`define CSD_SEL1_MASK     32'hF300770F
`define CSD_SEL2_MASK     32'h0000003C
`define CSD_DIV_MASK      32'h00FF0F0F
`define CSD_FDIV_MASK     32'h0000001F
`define CSD_PWR_MASK      32'h00000003
`define CSD_WDT_DIV       11'h7FF
`define CSD_SW_FAIL_BIT   7
`endif

/* logic/csd_pkg.sv */
// types shared by the clock select/divide block
// assumes: csd_cfg.svh on the include path
package csd_pkg;
  // enable strobes for each source, one-cycle pulses on clk
  typedef struct packed {
    logic fast_crystal;
    logic slow_crystal;
    logic fast_internal_oscillator;
    logic slow_internal_oscillator;
    logic ext_trigger;
  } csd_src_type;
  // stability flags of the oscillators
  typedef struct packed {
    logic crystal_stable;
    logic fast_irc_stable;
    logic slow_irc_stable;
  } csd_stable_type;
  // unlock sequence states
  typedef enum logic [1:0] {
    CSD_LOCKED = 2'b00,
    CSD_KEY1   = 2'b01,
    CSD_KEY2   = 2'b10,
    CSD_OPEN   = 2'b11
  } csd_lock_type;
endpackage : csd_pkg

/* verif/csd_osc_model.sv */
// oscillator and trigger sources feeding the clock select block, as enable pulses on clk
// assumes: one clk for everything; each source pulses once every PER cycles
module csd_osc_model #(
  parameter int FX = 3,
  parameter int SX = 7,
  parameter int FI = 2,
  parameter int SI = 5,
  parameter int EX = 4
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // source pulses
  output csd_pkg::csd_src_type src_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PER [5] = '{FX, SX, FI, SI, EX};
  logic [4:0] tick_vec;

  // every source free-runs, so old and new sources are both alive at any switch
  for (genvar i = 0; i < 5; i++) begin : g_src
    logic [3:0] cnt_reg;
    always_ff @(posedge clk) begin
      if (reset || cnt_reg == 4'(PER[i] - 1)) begin
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
    assign tick_vec[4-i] = (cnt_reg == 4'(PER[i] - 1));
  end

  // fast crystal sits in the top bit of the struct
  assign src_tick = tick_vec;
endmodule : csd_osc_model

/* verif/tb_top.sv */
// self-checking bench for the clock select and divide block
// assumes: source pulses come from csd_osc_model with the periods given below
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FX = 3, SX = 7, FI = 2, SI = 5, EX = 4;
  logic                     clk, reset, reg_write, reg_read, tick_clock_is_core;
  logic [7:0]               reg_addr;
  logic [31:0]              reg_wdata, reg_rdata;
  csd_pkg::csd_src_type     src_tick;
  csd_pkg::csd_stable_type  src_stable;
  logic                     core_clk_en, tick_clk_en, pwm_pair0_clk_en, pwm_pair1_clk_en;
  logic                     pwm_pair2_clk_en, serial_clk_en, timer_a_clk_en, timer_b_clk_en;
  logic                     converter_clk_en, watchdog_clk_en, divider_out_reg, dv_prev;
  logic [1:0]               crystal_enable_field;
  logic [10:0]              en_vec;
  int                       miscompares, n_checks, cycles;

  csd_clock_select uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .src_tick(src_tick),
    .src_stable(src_stable), .tick_clock_is_core(tick_clock_is_core),
    .core_clk_en(core_clk_en), .tick_clk_en(tick_clk_en), .pwm_pair0_clk_en(pwm_pair0_clk_en),
    .pwm_pair1_clk_en(pwm_pair1_clk_en), .pwm_pair2_clk_en(pwm_pair2_clk_en),
    .serial_clk_en(serial_clk_en), .timer_a_clk_en(timer_a_clk_en),
    .timer_b_clk_en(timer_b_clk_en), .converter_clk_en(converter_clk_en),
    .watchdog_clk_en(watchdog_clk_en), .divider_out_reg(divider_out_reg),
    .crystal_enable_field(crystal_enable_field));
  csd_osc_model #(.FX(FX), .SX(SX), .FI(FI), .SI(SI), .EX(EX)) osc (.clk(clk), .reset(reset),
    .src_tick(src_tick));

  // pulse outputs gathered by index; bit 10 marks a divider output toggle
  always_ff @(posedge clk) dv_prev <= divider_out_reg;
  assign en_vec = {divider_out_reg ^ dv_prev, core_clk_en, tick_clk_en, pwm_pair0_clk_en,
    pwm_pair1_clk_en, pwm_pair2_clk_en, serial_clk_en, timer_a_clk_en, timer_b_clk_en,
    converter_clk_en, watchdog_clk_en};

  // clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  // cycles between pulses; the wait for the first pulse and the first interval are skipped as they may span a change
  task automatic gap(input int idx, input int exp);
    int t;
    t = 0;
    repeat (3) begin
      t = 0;
      do begin
        @(posedge clk);
        #1;
        t++;
      end while (en_vec[idx] !== 1'b1 && t < 600);
    end
    check(32'(t), 32'(exp));
  endtask : gap

  task automatic s_reset();
    rd(8'h10, 32'h0000003F);
    rd(8'h14, 32'hAFFFFFFF);
    rd(8'h1C, 32'h000000EF);
    rd(8'h18, 32'h0);
    rd(8'h24, 32'h0);
    wr(8'h40, 32'h12345678);
    rd(8'h40, 32'h0);
  endtask : s_reset

  task automatic s_lock();
    wr(8'h10, 32'h1B);
    rd(8'h10, 32'h3F);
    wr(8'h14, 32'hA0000000);
    rd(8'h14, 32'hA0000003);
    wr(8'h30, 32'h59);
    wr(8'h30, 32'h16);
    wr(8'h30, 32'h88);
    rd(8'h30, 32'h1);
    wr(8'h10, 32'h3B);
    rd(8'h10, 32'h3B);
    gap(9, SI);
    gap(8, 2 * FI);
    wr(8'h10, 32'h39);
    gap(9, SI);
  endtask : s_lock

  task automatic s_core_div();
    wr(8'h10, 32'h3F);
    wr(8'h18, 32'h3);
    gap(9, 4 * FI);
    gap(7, 4 * FI);
    gap(6, 4 * FI);
    gap(5, 4 * FI);
    wr(8'h10, 32'h1F);
    gap(8, 8 * FI);
    @(posedge clk);
    tick_clock_is_core <= 1'b1;
    gap(8, 4 * FI);
    @(posedge clk);
    tick_clock_is_core <= 1'b0;
    wr(8'h18, 32'h0);
    gap(9, FI);
  endtask : s_core_div

  task automatic s_crystal();
    wr(8'h00, 32'h1);
    #1;
    check(32'(crystal_enable_field), 32'h1);
    wr(8'h14, 32'hA0000000);
    wr(8'h18, 32'h00020200);
    gap(4, 3 * FX);
    gap(1, 3 * FX);
    gap(0, FX);
    gap(3, FX);
    wr(8'h00, 32'h2);
    gap(4, 3 * SX);
    wr(8'h00, 32'h3);
    #1;
    check(32'(crystal_enable_field), 32'h3);
    gap(4, 3 * FX);
  endtask : s_crystal

  task automatic s_sources();
    wr(8'h14, 32'hA200370F);
    gap(4, 3 * FI);
    gap(1, 3 * FI);
    gap(0, SI);
    gap(3, FI);
    gap(2, EX);
  endtask : s_sources

  task automatic s_timers();
    logic [2:0] codes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b111};
    int         exps [5]  = '{FX, SI, FI, EX, FI};
    for (int i = 0; i < 5; i++) begin
      wr(8'h14, 32'hA0000000 | (32'(codes[i]) << 12));
      gap(2, exps[i]);
    end
    wr(8'h14, 32'hA0004000);
    gap(2, FI);
  endtask : s_timers

  task automatic s_divider();
    int n;
    n = 0;
    wr(8'h1C, 32'h2C);
    wr(8'h24, 32'h11);
    gap(10, 2 * FI);
    wr(8'h24, 32'h10);
    gap(10, FI);
    wr(8'h24, 32'h0);
    repeat (4) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      #1;
      if (en_vec[10] !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
  endtask : s_divider

  task automatic s_fail();
    @(posedge clk);
    src_stable <= 3'b110;
    wr(8'h10, 32'h3B);
    rd(8'h0C, 32'h91);
    wr(8'h0C, 32'h80);
    rd(8'h0C, 32'h11);
    @(posedge clk);
    src_stable <= 3'b111;
  endtask : s_fail

  // main sequence
  initial begin
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    src_stable = 3'b111;
    tick_clock_is_core = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    s_reset();
    s_lock();
    s_core_div();
    s_crystal();
    s_sources();
    s_timers();
    s_divider();
    s_fail();
    print_verdict();
  end
endmodule : tb_top
